// File: src/pstb_pkg.sv
// package of command codes, bit positions and widths for the status bank
// Function
// - paged output-current status at code 7B, bit 7 overcurrent fault.
// - output-current status bit 6: overcurrent with undervoltage fault.
// - output-current status bit 3: current share fault; others unused.
// - global input status at code 7C, bit 7 input overvoltage fault.
// - input bit 4 undervoltage, masked until input first exceeds threshold.
// - input status bit 2 input overcurrent; other bits unused.
// - global temperature status at code 7D, bit 7 over-temperature fault.
// - temperature bit 6 over-temperature warning, separate from fault.
// - temperature bit 4 under-temperature fault; others unused.
// - global comm/memory/logic status at code 7E, bit 7 bad command.
// - comm/memory/logic bit 6: command carried invalid data.
// - comm/memory/logic bit 5: packet error check failure.
// - comm/memory/logic bit 1: other communication fault; bit 2 unused.
// - comm/memory/logic bit 0: other memory or logic fault.
// - global vendor status at code 80, bit 1 one-time store full.
// - input voltage at code 88, global two-byte value in millivolts.
// - input current at code 89, global two-byte value, hundredths amp.
// - output voltage at code 8B, paged two-byte value in millivolts.
`default_nettype none
package pstb_pkg;
   localparam logic [7:0] CMD_IOUT_STAT = 8'h7B;
   localparam logic [7:0] CMD_INPUT_STAT = 8'h7C;
   localparam logic [7:0] CMD_TEMP_STAT = 8'h7D;
   localparam logic [7:0] CMD_CML_STAT = 8'h7E;
   localparam logic [7:0] CMD_VENDOR_STAT = 8'h80;
   localparam logic [7:0] CMD_VIN_READ = 8'h88;
   localparam logic [7:0] CMD_IIN_READ = 8'h89;
   localparam logic [7:0] CMD_VOUT_READ = 8'h8B;
   localparam int IOUT_OC_BIT = 7;
   localparam int IOUT_OCUV_BIT = 6;
   localparam int IOUT_SHARE_BIT = 3;
   localparam int IN_OV_BIT = 7;
   localparam int IN_UV_BIT = 4;
   localparam int IN_OC_BIT = 2;
   localparam int TEMP_OT_FAULT_BIT = 7;
   localparam int TEMP_OT_WARN_BIT = 6;
   localparam int TEMP_UT_FAULT_BIT = 4;
   localparam int CML_BAD_CMD_BIT = 7;
   localparam int CML_BAD_DATA_BIT = 6;
   localparam int CML_PEC_BIT = 5;
   localparam int CML_OTHER_COMM_BIT = 1;
   localparam int CML_OTHER_MEM_BIT = 0;
   localparam int VENDOR_OTP_FULL_BIT = 1;
   localparam logic [7:0] STAT_RESET = 8'h00;
   localparam logic [15:0] WORD_RESET = 16'h0000;
   localparam int NUM_PAGES = 2;
   localparam int PAGE_W = 1;
   // event sources feeding the status bank
   typedef struct packed {
      logic oc;
      logic ocuv;
      logic share;
   } pstb_out_ev_t;
   typedef struct packed {
      logic in_ov;
      logic in_uv;
      logic in_oc;
      logic in_above_uv;
      logic ot_fault;
      logic ot_warn;
      logic ut_fault;
      logic bad_cmd;
      logic bad_data;
      logic pec_err;
      logic other_comm;
      logic other_mem;
      logic otp_full;
   } pstb_glob_ev_t;
endpackage : pstb_pkg
`default_nettype wire

// File: src/pstb_if.sv
// interface carrying a read request and its answer between bank parts
`default_nettype none
interface pstb_if;
   logic req;
   logic [7:0] cmd;
   logic page;
   logic hit;
   logic two_byte;
   logic [15:0] data;
   modport decoder (input req, input cmd, input page,
                    output hit, output two_byte, output data);
   modport top (output req, output cmd, output page,
                input hit, input two_byte, input data);
endinterface : pstb_if
`default_nettype wire

// File: src/pstb_page_word.sv
// per-page register for two-byte readings, registered read port
`default_nettype none
module pstb_page_word #(
   parameter int PAGES = pstb_pkg::NUM_PAGES
) (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rstn,
   // update side
   input wire logic i_we,
   input wire logic [pstb_pkg::PAGE_W-1:0] i_wpage,
   input wire logic [15:0] i_wdata,
   // read side
   input wire logic [pstb_pkg::PAGE_W-1:0] i_rpage,
   output logic [15:0] o_rdata
);
   typedef struct packed {
      logic [PAGES-1:0][15:0] mem;
      logic [15:0] rd;
   } pstb_pw_state_t;
   pstb_pw_state_t st;
   pstb_pw_state_t next_st;
   initial begin
      if (PAGES < 1 || PAGES > (1 << pstb_pkg::PAGE_W)) begin
         $error("page count does not fit page index");
      end
   end
   always_comb begin
      next_st = st;
      if (i_we && (int'(i_wpage) < PAGES)) begin
         next_st.mem[i_wpage] = i_wdata;
      end
      next_st.rd = (int'(i_rpage) < PAGES) ? st.mem[i_rpage]
                                           : pstb_pkg::WORD_RESET;
   end
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end
   assign o_rdata = st.rd;
endmodule : pstb_page_word
`default_nettype wire

// File: src/pstb_decode.sv
// command decoder: chooses the byte or word answered for a code
`default_nettype none
module pstb_decode (
   // request and answer
   pstb_if.decoder bus,
   // status bytes and readings
   input wire logic [7:0] i_iout_stat,
   input wire logic [7:0] i_input_stat,
   input wire logic [7:0] i_temp_stat,
   input wire logic [7:0] i_cml_stat,
   input wire logic [7:0] i_vendor_stat,
   input wire logic [15:0] i_vin,
   input wire logic [15:0] i_iin,
   input wire logic [15:0] i_vout
);
   always_comb begin
      bus.hit = 1'b1;
      bus.two_byte = 1'b0;
      bus.data = pstb_pkg::WORD_RESET;
      case (bus.cmd)
         pstb_pkg::CMD_IOUT_STAT: bus.data = {8'h00, i_iout_stat};
         pstb_pkg::CMD_INPUT_STAT: bus.data = {8'h00, i_input_stat};
         pstb_pkg::CMD_TEMP_STAT: bus.data = {8'h00, i_temp_stat};
         pstb_pkg::CMD_CML_STAT: bus.data = {8'h00, i_cml_stat};
         pstb_pkg::CMD_VENDOR_STAT: bus.data = {8'h00, i_vendor_stat};
         pstb_pkg::CMD_VIN_READ: begin
            bus.two_byte = 1'b1;
            bus.data = i_vin;
         end
         pstb_pkg::CMD_IIN_READ: begin
            bus.two_byte = 1'b1;
            bus.data = i_iin;
         end
         pstb_pkg::CMD_VOUT_READ: begin
            bus.two_byte = 1'b1;
            bus.data = i_vout;
         end
         default: begin
            bus.hit = 1'b0;
         end
      endcase
   end
endmodule : pstb_decode
`default_nettype wire

// File: src/pstb_bank.sv
// status and telemetry bank: sticky status bytes and readings by code
`default_nettype none
module pstb_bank #(
   parameter int PAGES = pstb_pkg::NUM_PAGES
) (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rstn,
   // fault events, one bit per page for output faults
   input wire logic [PAGES-1:0] i_out_oc,
   input wire logic [PAGES-1:0] i_out_ocuv,
   input wire logic [PAGES-1:0] i_out_share,
   input wire pstb_pkg::pstb_glob_ev_t i_glob_ev,
   // clear strobes from the command layer
   input wire logic i_clear_all,
   // readings from the measurement logic
   input wire logic i_vin_we,
   input wire logic [15:0] i_vin,
   input wire logic i_iin_we,
   input wire logic [15:0] i_iin,
   input wire logic i_vout_we,
   input wire logic [pstb_pkg::PAGE_W-1:0] i_vout_page,
   input wire logic [15:0] i_vout,
   // command read port
   input wire logic i_rd_req,
   input wire logic i_wr_req,
   input wire logic [7:0] i_cmd,
   input wire logic [pstb_pkg::PAGE_W-1:0] i_page,
   output logic o_rd_valid,
   output logic o_rd_hit,
   output logic o_rd_two_byte,
   output logic [15:0] o_rd_data
);
   typedef struct packed {
      logic [PAGES-1:0][7:0] iout;
      logic [7:0] inp;
      logic [7:0] temp;
      logic [7:0] cml;
      logic [7:0] vendor;
      logic [15:0] vin;
      logic [15:0] iin;
      logic uv_armed;
      logic pend;
      logic pend_paged_vout;
      logic pend_hit;
      logic pend_two;
      logic [15:0] pend_data;
      logic rd_valid;
      logic rd_hit;
      logic rd_two;
      logic [15:0] rd_data;
   } pstb_bank_state_t;
   pstb_bank_state_t st;
   pstb_bank_state_t next_st;
   logic [15:0] vout_word;
   logic [7:0] iout_sel;
   pstb_if dec_if ();

   initial begin
      if (PAGES < 1 || PAGES > (1 << pstb_pkg::PAGE_W)) begin
         $error("page count does not fit page index");
      end
   end

   // sticky set: an event in the clear cycle still lands
   function automatic logic [7:0] stick(input logic [7:0] cur,
                                        input logic [7:0] ev,
                                        input logic clr);
      stick = (clr ? 8'h00 : cur) | ev;
   endfunction : stick

   pstb_page_word #(.PAGES(PAGES)) u_vout (
      .i_clk(i_clk),
      .i_rstn(i_rstn),
      .i_we(i_vout_we),
      .i_wpage(i_vout_page),
      .i_wdata(i_vout),
      .i_rpage(i_page),
      .o_rdata(vout_word)
   );

   assign iout_sel = (int'(i_page) < PAGES) ? st.iout[i_page]
                                            : pstb_pkg::STAT_RESET;
   assign dec_if.req = i_rd_req;
   assign dec_if.cmd = i_cmd;
   assign dec_if.page = i_page;

   pstb_decode u_dec (
      .bus(dec_if.decoder),
      .i_iout_stat(iout_sel),
      .i_input_stat(st.inp),
      .i_temp_stat(st.temp),
      .i_cml_stat(st.cml),
      .i_vendor_stat(st.vendor),
      .i_vin(st.vin),
      .i_iin(st.iin),
      .i_vout(vout_word)
   );

   always_comb begin
      logic [7:0] ev;
      ev = 8'h00;
      next_st = st;
      next_st.rd_valid = 1'b0;
      for (int p = 0; p < PAGES; p++) begin
         ev = 8'h00;
         ev[pstb_pkg::IOUT_OC_BIT] = i_out_oc[p];
         ev[pstb_pkg::IOUT_OCUV_BIT] = i_out_ocuv[p];
         ev[pstb_pkg::IOUT_SHARE_BIT] = i_out_share[p];
         next_st.iout[p] = stick(st.iout[p], ev, i_clear_all);
      end
      // undervoltage stays hidden until input first rises past threshold
      if (i_glob_ev.in_above_uv) begin
         next_st.uv_armed = 1'b1;
      end
      ev = 8'h00;
      ev[pstb_pkg::IN_OV_BIT] = i_glob_ev.in_ov;
      ev[pstb_pkg::IN_UV_BIT] = i_glob_ev.in_uv & st.uv_armed;
      ev[pstb_pkg::IN_OC_BIT] = i_glob_ev.in_oc;
      next_st.inp = stick(st.inp, ev, i_clear_all);
      ev = 8'h00;
      ev[pstb_pkg::TEMP_OT_FAULT_BIT] = i_glob_ev.ot_fault;
      ev[pstb_pkg::TEMP_OT_WARN_BIT] = i_glob_ev.ot_warn;
      ev[pstb_pkg::TEMP_UT_FAULT_BIT] = i_glob_ev.ut_fault;
      next_st.temp = stick(st.temp, ev, i_clear_all);
      ev = 8'h00;
      // reads of unknown codes also count as bad commands
      ev[pstb_pkg::CML_BAD_CMD_BIT] = i_glob_ev.bad_cmd;
      ev[pstb_pkg::CML_BAD_DATA_BIT] = i_glob_ev.bad_data;
      ev[pstb_pkg::CML_PEC_BIT] = i_glob_ev.pec_err;
      ev[pstb_pkg::CML_OTHER_COMM_BIT] = i_glob_ev.other_comm;
      ev[pstb_pkg::CML_OTHER_MEM_BIT] = i_glob_ev.other_mem;
      if (st.pend && !st.pend_hit) begin
         ev[pstb_pkg::CML_BAD_CMD_BIT] = 1'b1;
      end
      next_st.cml = stick(st.cml, ev, i_clear_all);
      ev = 8'h00;
      ev[pstb_pkg::VENDOR_OTP_FULL_BIT] = i_glob_ev.otp_full;
      next_st.vendor = stick(st.vendor, ev, i_clear_all);
      if (i_vin_we) begin
         next_st.vin = i_vin;
      end
      if (i_iin_we) begin
         next_st.iin = i_iin;
      end
      // writes never touch the bank; they are only dropped
      next_st.pend = i_rd_req & ~i_wr_req;
      next_st.pend_paged_vout = i_rd_req &&
                                (i_cmd == pstb_pkg::CMD_VOUT_READ);
      // first stage holds the decode, so back to back reads never collide
      next_st.pend_hit = dec_if.hit;
      next_st.pend_two = dec_if.two_byte;
      next_st.pend_data = dec_if.data;
      // second stage is the answer; it stands one cycle then drops
      next_st.rd_valid = st.pend;
      next_st.rd_hit = st.pend & st.pend_hit;
      next_st.rd_two = st.pend & st.pend_two;
      next_st.rd_data = pstb_pkg::WORD_RESET;
      if (st.pend && st.pend_hit) begin
         next_st.rd_data = st.pend_data;
      end
      // vout word comes a cycle late out of its page register
      if (st.pend && st.pend_paged_vout) begin
         next_st.rd_data = vout_word;
      end
   end

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign o_rd_valid = st.rd_valid;
   assign o_rd_hit = st.rd_hit;
   assign o_rd_two_byte = st.rd_two;
   assign o_rd_data = st.rd_data;
endmodule : pstb_bank
`default_nettype wire

// File: tb/pstb_bank_checker.sv
// assertions on the read port of the status bank
`default_nettype none
module pstb_checker (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rstn,
   // read request
   input wire logic i_rd_req,
   input wire logic i_wr_req,
   input wire logic [7:0] i_cmd,
   // read answer
   input wire logic o_rd_valid,
   input wire logic o_rd_hit,
   input wire logic o_rd_two_byte,
   input wire logic [15:0] o_rd_data
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rstn);
   logic take;
   logic word_cmd;
   logic known_cmd;
   logic [15:0] zm;
   // bits that must read zero for each code
   function automatic logic [15:0] zmask(input logic [7:0] c);
      case (c)
         8'h7B: zmask = 16'hFF37;
         8'h7C: zmask = 16'hFF6B;
         8'h7D: zmask = 16'hFF2F;
         8'h7E: zmask = 16'hFF1C;
         8'h80: zmask = 16'hFFFD;
         default: zmask = 16'h0000;
      endcase
   endfunction : zmask
   assign take = i_rd_req && !i_wr_req;
   assign word_cmd = i_cmd inside {8'h88, 8'h89, 8'h8B};
   assign known_cmd = word_cmd || i_cmd inside {8'h7B, 8'h7C, 8'h7D, 8'h7E,
      8'h80};
   assign zm = zmask(i_cmd);
   sequence s_take;
      i_rd_req && !i_wr_req;
   endsequence
   sequence s_answer;
      ##2 o_rd_valid;
   endsequence
   AST_VALID_LAT: assert property (s_take |-> s_answer)
      else $error("read answer missing two cycles after request");
   AST_NO_SPURIOUS: assert property (o_rd_valid |-> $past(take, 2))
      else $error("answer without a request");
   AST_WR_IGNORED: assert property (i_wr_req |-> ##2 !o_rd_valid)
      else $error("write attempt answered");
   AST_IDLE_ZERO: assert property (!o_rd_valid |->
      o_rd_data == 16'h0000)
      else $error("data not zero while idle");
   AST_WORD_KIND: assert property (take && word_cmd |->
      ##2 (o_rd_valid && o_rd_hit && o_rd_two_byte))
      else $error("reading code not answered as a word");
   AST_BYTE_KIND: assert property (take && known_cmd && !word_cmd |->
      ##2 (o_rd_hit && !o_rd_two_byte && o_rd_data[15:8] == 8'h00))
      else $error("status code not answered as a byte");
   AST_UNKNOWN: assert property (take && !known_cmd |->
      ##2 (o_rd_valid && !o_rd_hit && o_rd_data == 16'h0000))
      else $error("unknown code answered with data");
   AST_UNUSED_ZERO: assert property (o_rd_valid |->
      (o_rd_data & $past(zm, 2)) == 16'h0000)
      else $error("unused status bit set");
endmodule : pstb_checker
bind pstb_bank pstb_checker chk_u (.i_clk(i_clk), .i_rstn(i_rstn),
   .i_rd_req(i_rd_req), .i_wr_req(i_wr_req), .i_cmd(i_cmd),
   .o_rd_valid(o_rd_valid), .o_rd_hit(o_rd_hit),
   .o_rd_two_byte(o_rd_two_byte), .o_rd_data(o_rd_data));
`default_nettype wire

// File: tb/pstb_host.sv
// host model issuing command reads and writes to the bank
`default_nettype none
module pstb_host (
   // clock
   input wire logic i_clk,
   // request side
   output logic o_rd_req,
   output logic o_wr_req,
   output logic [7:0] o_cmd,
   output logic [pstb_pkg::PAGE_W-1:0] o_page,
   // answer side
   input wire logic i_valid,
   input wire logic i_hit,
   input wire logic i_two,
   input wire logic [15:0] i_data
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      o_rd_req = 1'b0;
      o_wr_req = 1'b0;
      o_cmd = 8'hFF;
      o_page = '0;
   end
   // released code lines show the inverse, never the last value
   task access(input logic wr, input logic [7:0] c,
      input logic [pstb_pkg::PAGE_W-1:0] p, output logic got,
      output logic hit, output logic [15:0] d);
      got = 1'b0;
      hit = 1'b0;
      d = 16'h0000;
      @(posedge i_clk);
      o_rd_req <= 1'b1;
      o_wr_req <= wr;
      o_cmd <= c;
      o_page <= p;
      @(posedge i_clk);
      o_rd_req <= 1'b0;
      o_wr_req <= 1'b0;
      o_cmd <= ~c;
      o_page <= ~p;
      for (int n = 0; n < 3 && !got; n++) begin
         @(posedge i_clk);
         #1;
         got = i_valid;
         hit = i_hit;
         d = i_data;
      end
   endtask : access
endmodule : pstb_host
`default_nettype wire

// File: tb/pmbus_status_telemetry_bank_tb.sv
// self-checking bench for the status and telemetry bank
`default_nettype none
module pmbus_status_telemetry_bank_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic i_clk = 1'b0;
   logic i_rstn = 1'b0;
   logic [1:0] oc = '0, ocuv = '0, share = '0;
   pstb_pkg::pstb_glob_ev_t glob = '0;
   logic clr_all = 1'b0, vin_we = 1'b0, iin_we = 1'b0, vout_we = 1'b0;
   logic [15:0] vin = '0, iin = '0, vout = '0;
   logic vpage = 1'b0;
   logic rd_req, wr_req, page, valid, hit, two, got, h;
   logic [7:0] cmd;
   logic [15:0] data, d;
   int mismatches = 0, total_checks = 0, cycles = 0;
   localparam logic [7:0] CODES [8] = '{8'h7B, 8'h7C, 8'h7D, 8'h7E, 8'h80,
      8'h88, 8'h89, 8'h8B};
   // event index, code, expected byte
   localparam logic [27:0] TBL [11] = '{28'hC7C0080, 28'hA7C0004,
      28'h87D0080, 28'h77D0040, 28'h67D0010, 28'h57E0080, 28'h47E0040,
      28'h37E0020, 28'h27E0002, 28'h17E0001, 28'h0800002};
   pstb_bank dut_u (.i_clk(i_clk), .i_rstn(i_rstn), .i_out_oc(oc),
      .i_out_ocuv(ocuv), .i_out_share(share), .i_glob_ev(glob),
      .i_clear_all(clr_all), .i_vin_we(vin_we), .i_vin(vin),
      .i_iin_we(iin_we), .i_iin(iin), .i_vout_we(vout_we),
      .i_vout_page(vpage), .i_vout(vout), .i_rd_req(rd_req),
      .i_wr_req(wr_req), .i_cmd(cmd), .i_page(page), .o_rd_valid(valid),
      .o_rd_hit(hit), .o_rd_two_byte(two), .o_rd_data(data));
   pstb_host host_u (.i_clk(i_clk), .o_rd_req(rd_req), .o_wr_req(wr_req),
      .o_cmd(cmd), .o_page(page), .i_valid(valid), .i_hit(hit),
      .i_two(two), .i_data(data));
   always #5 i_clk = ~i_clk;
   // the whole run needs well under a thousand cycles
   always @(posedge i_clk) begin
      cycles++;
      if (cycles == 5000) begin
         mismatches++;
         finish_test();
      end
   end
   task chk(input logic [15:0] got_v, input logic [15:0] exp_v);
      total_checks++;
      if (got_v !== exp_v) begin
         mismatches++;
         $display("BAD t=%0t got=%h exp=%h", $time, got_v, exp_v);
      end
   endtask : chk
   task rd(input logic [7:0] c, input logic p, input logic eh,
      input logic [15:0] exp_v);
      logic ew;
      ew = c inside {8'h88, 8'h89, 8'h8B};
      host_u.access(1'b0, c, p, got, h, d);
      chk({14'h0000, got, h}, {14'h0000, 1'b1, eh});
      chk(d, exp_v);
      chk({15'h0000, two}, {15'h0000, ew});
   endtask : rd
   task ev(input logic [12:0] v);
      @(posedge i_clk);
      glob <= pstb_pkg::pstb_glob_ev_t'(v);
      @(posedge i_clk);
      glob <= '0;
   endtask : ev
   task clr;
      @(posedge i_clk);
      clr_all <= 1'b1;
      @(posedge i_clk);
      clr_all <= 1'b0;
   endtask : clr
   task finish_test;
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : finish_test
   initial begin
      repeat (12) @(posedge i_clk);
      i_rstn <= 1'b1;
      foreach (CODES[i]) rd(CODES[i], 1'b0, 1'b1, 16'h0000);
      $display("test reset values done");
      ev(13'h0800);
      rd(8'h7C, 1'b0, 1'b1, 16'h0000);
      ev(13'h0200);
      ev(13'h0800);
      rd(8'h7C, 1'b0, 1'b1, 16'h0010);
      clr;
      $display("test undervoltage mask done");
      foreach (TBL[i]) begin
         ev(13'h0001 << TBL[i][27:24]);
         rd(TBL[i][23:16], 1'b0, 1'b1, TBL[i][15:0]);
         clr;
      end
      $display("test global status done");
      @(posedge i_clk);
      oc <= 2'b10;
      ocuv <= 2'b01;
      share <= 2'b01;
      @(posedge i_clk);
      {oc, ocuv, share} <= '0;
      rd(8'h7B, 1'b1, 1'b1, 16'h0080);
      rd(8'h7B, 1'b0, 1'b1, 16'h0048);
      clr;
      rd(8'h7B, 1'b1, 1'b1, 16'h0000);
      $display("test paged status done");
      @(posedge i_clk);
      {vin_we, iin_we, vout_we} <= 3'h7;
      vin <= 16'h2EE0;
      iin <= 16'hFF9C;
      vout <= 16'h0384;
      @(posedge i_clk);
      {vin_we, iin_we} <= 2'h0;
      vpage <= 1'b1;
      vout <= 16'h04B0;
      @(posedge i_clk);
      vout_we <= 1'b0;
      rd(8'h88, 1'b0, 1'b1, 16'h2EE0);
      rd(8'h89, 1'b0, 1'b1, 16'hFF9C);
      rd(8'h8B, 1'b0, 1'b1, 16'h0384);
      rd(8'h8B, 1'b1, 1'b1, 16'h04B0);
      $display("test readings done");
      host_u.access(1'b1, 8'h88, 1'b0, got, h, d);
      chk({15'h0000, got}, 16'h0000);
      rd(8'h88, 1'b0, 1'b1, 16'h2EE0);
      rd(8'h8A, 1'b0, 1'b0, 16'h0000);
      rd(8'h7E, 1'b0, 1'b1, 16'h0080);
      $display("test refused access done");
      finish_test();
   end
endmodule : pmbus_status_telemetry_bank_tb
`default_nettype wire
